// [hw/pot_cmd_pkg.sv]
// Constants for the dual wiper serial command unit
package pot_cmd_pkg;
    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam int          FRAME_BITS = 24;
    localparam logic [4:0]  FRAME_CNT  = 5'h18;
    localparam logic [4:0]  CNT_MAX    = 5'h1f;
    localparam int          CMD_MSB    = 23;
    localparam int          CMD_LSB    = 20;
    localparam int          ADDR_MSB   = 19;
    localparam int          ADDR_LSB   = 16;
    // ----------------------------------------
    // Wiper codes
    // ----------------------------------------
    localparam int          WIPER_W    = 10;
    localparam logic [9:0]  WIPER_ZERO = 10'h000;
    localparam logic [9:0]  WIPER_ONE  = 10'h001;
    localparam logic [9:0]  WIPER_MID  = 10'h200;
    localparam logic [9:0]  WIPER_FULL = 10'h3ff;
    localparam logic [5:0]  WIPER_PAD  = 6'h00;
    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [3:0]  CMD_NOP     = 4'h0;
    localparam logic [3:0]  CMD_RESTORE = 4'h1;
    localparam logic [3:0]  CMD_STORE_W = 4'h2;
    localparam logic [3:0]  CMD_STORE_U = 4'h3;
    localparam logic [3:0]  CMD_READ_NV = 4'h9;
    localparam logic [3:0]  CMD_READ_W  = 4'ha;
    localparam logic [3:0]  CMD_WRITE_W = 4'hb;
    localparam logic [3:0]  CMD_DOUBLE  = 4'hc;
    localparam logic [3:0]  CMD_INC     = 4'he;
    // ----------------------------------------
    // Nonvolatile map
    // ----------------------------------------
    localparam logic [3:0]  NV_WIPER_ONE = 4'h0;
    localparam logic [3:0]  NV_WIPER_TWO = 4'h1;
    localparam logic [3:0]  NV_USER_LAST = 4'he;
    localparam logic [3:0]  NV_TOLERANCE = 4'hf;
    localparam logic [15:0] NV_WIPER_INIT = 16'h0200;
    localparam logic [15:0] NV_USER_INIT  = 16'h0000;
    // Tolerance word: sign bit, 7-bit integer percent, 8-bit fraction
    localparam int          TOL_SIGN_BIT = 15;
    localparam int          TOL_INT_LSB  = 8;
    localparam logic        TOL_POSITIVE = 1'b1;
    localparam logic [6:0]  TOL_INT_PCT  = 7'h00;
    localparam logic [7:0]  TOL_FRAC     = 8'h00;
    // ----------------------------------------
    // Pin synchroniser idle value {recall_n, wp_n, cs_n, sclk, sdi}
    // ----------------------------------------
    localparam logic [4:0]  SYNC_IDLE = 5'h1c;

    typedef enum logic [0:0] {
        FR_IDLE   = 1'b0,
        FR_ACTIVE = 1'b1
    } frame_state_e;
endpackage : pot_cmd_pkg

// [hw/dual_pot_serial_command_unit.sv]
// Serial command decoder, wiper registers and nonvolatile store of a dual potentiometer
`timescale 1ns/1ps

// What this block does
// (RULE_01) Each wiper is a 10-bit code; zero is terminal B, upward toward A.
// (RULE_02) Tolerance word low byte is fraction, D7 one half down to D0.
// (RULE_03) Top byte 0xB0 loads the 10-bit data field into wiper one.
// (RULE_04) Address nibble picks channel; top byte 0xB1 loads wiper two.
// (RULE_05) Top byte 0xE0 raises wiper one by one code, data ignored.
// (RULE_06) Top byte 0x20 copies wiper one into nonvolatile slot one.
// (RULE_07) Write-protect low refuses every nonvolatile write.
// (RULE_08) Top byte 0x10 reloads wiper one from nonvolatile slot one.
// (RULE_09) Wipers reload from nonvolatile slots at power-on and on recall strobe.
// (RULE_10) Top byte 0xC0 doubles wiper one, 0xC1 doubles wiper two.
// (RULE_11) Doubling midscale gives full scale, never overflows.
// (RULE_12) Store-user frame writes its 16 data bits to the addressed word.
// (RULE_13) Thirteen user nonvolatile words of sixteen bits each.
// (RULE_14) User words are written by code 3, read back by code 9.
// (RULE_15) After read-user frame the next frame returns the word in low 16 bits.
// (RULE_16) Top byte 0xA0 prepares readback: next frame returns command byte and code.
// (RULE_17) Without prepared readback the output echoes the previous frame.
// (RULE_18) Tolerance top bit is sign, one positive; next seven bits integer percent.
// (RULE_19) Chip select strobe without clocks repeats the previous command.
// (RULE_20) Doubling zero gives one; doubling at or above midscale saturates full.
// (RULE_21) Address 0 wiper one, 1 wiper two, 2 to 14 user, 15 tolerance.
module dual_pot_serial_command_unit (
    input  wire logic       mclk,               // System clock, 25 MHz
    input  wire logic       rstn,               // Asynchronous reset, active low
    input  wire logic       sclk,               // Serial link clock pin
    input  wire logic       cs_n,               // Frame select pin, active low
    input  wire logic       sdi,                // Serial data in pin
    input  wire logic       wp_n,               // Write protect pin, active low
    input  wire logic       preset_recall_n,    // Recall strobe pin, active low
    output logic            sdo,                // Serial data out
    output logic [9:0]      wiper_position_one, // Wiper one code
    output logic [9:0]      wiper_position_two  // Wiper two code
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [9:0] dbl_code(input logic [9:0] c);
        if (c == pot_cmd_pkg::WIPER_ZERO) begin
            return pot_cmd_pkg::WIPER_ONE;
        end
        if (c >= pot_cmd_pkg::WIPER_MID) begin
            return pot_cmd_pkg::WIPER_FULL;
        end
        return {c[8:0], 1'b0};
    endfunction : dbl_code

    function automatic logic [9:0] inc_code(input logic [9:0] c);
        if (c == pot_cmd_pkg::WIPER_FULL) begin
            return c;
        end
        return c + pot_cmd_pkg::WIPER_ONE;
    endfunction : inc_code

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0]     sync1_ff;
    logic [4:0]     sync2_ff;
    logic [4:0]     prev_ff;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= pot_cmd_pkg::SYNC_IDLE;
            sync2_ff <= pot_cmd_pkg::SYNC_IDLE;
            prev_ff  <= pot_cmd_pkg::SYNC_IDLE;
        end else begin
            sync1_ff <= {preset_recall_n, wp_n, cs_n, sclk, sdi};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    logic sdi_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic wp_s;
    logic recall_rise;
    assign sdi_s       = sync2_ff[0];
    assign sclk_rise   = sync2_ff[1] & ~prev_ff[1];
    assign sclk_fall   = ~sync2_ff[1] & prev_ff[1];
    assign cs_fall     = ~sync2_ff[2] & prev_ff[2];
    assign cs_rise     = sync2_ff[2] & ~prev_ff[2];
    assign wp_s        = sync2_ff[3];
    assign recall_rise = sync2_ff[4] & ~prev_ff[4];

    // ----------------------------------------
    // Frame shifter
    // ----------------------------------------
    pot_cmd_pkg::frame_state_e  state_ff;
    logic [4:0]                 cnt_ff;
    logic [23:0]                rx_ff;
    logic [23:0]                tx_ff;
    logic [23:0]                reply_ff;
    logic                       sdo_ff;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= pot_cmd_pkg::FR_IDLE;
            cnt_ff   <= 5'h00;
            rx_ff    <= 24'h000000;
            tx_ff    <= 24'h000000;
            sdo_ff   <= 1'b0;
        end else begin
            case (state_ff)
                pot_cmd_pkg::FR_IDLE: begin
                    if (cs_fall) begin
                        state_ff <= pot_cmd_pkg::FR_ACTIVE;
                        cnt_ff   <= 5'h00;
                        tx_ff    <= reply_ff;           // [RULE_15] [RULE_16] [RULE_17]
                        sdo_ff   <= reply_ff[pot_cmd_pkg::CMD_MSB];
                    end
                end
                pot_cmd_pkg::FR_ACTIVE: begin
                    if (cs_rise) begin
                        state_ff <= pot_cmd_pkg::FR_IDLE;
                    end else if (sclk_rise) begin
                        rx_ff <= {rx_ff[22:0], sdi_s};
                        if (cnt_ff != pot_cmd_pkg::CNT_MAX) begin
                            cnt_ff <= cnt_ff + 5'h01;
                        end
                    end else if (sclk_fall) begin
                        tx_ff  <= {tx_ff[22:0], 1'b0};
                        sdo_ff <= tx_ff[22];
                    end
                end
                default: begin
                    state_ff <= pot_cmd_pkg::FR_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Command execution strobe
    // ----------------------------------------
    logic           frame_end;
    logic           exec_go;
    logic [23:0]    exec_word;
    logic [23:0]    last_cmd_ff;
    logic [3:0]     cmd;
    logic [3:0]     addr;
    logic           chan;

    assign frame_end = (state_ff == pot_cmd_pkg::FR_ACTIVE) & cs_rise;
    // A full frame runs what was shifted in; an empty strobe repeats the last one
    assign exec_go   = frame_end & ((cnt_ff == pot_cmd_pkg::FRAME_CNT) |
                                    (cnt_ff == 5'h00));       // [RULE_19]
    assign exec_word = (cnt_ff == 5'h00) ? last_cmd_ff : rx_ff; // [RULE_19]
    assign cmd       = exec_word[pot_cmd_pkg::CMD_MSB:pot_cmd_pkg::CMD_LSB];
    assign addr      = exec_word[pot_cmd_pkg::ADDR_MSB:pot_cmd_pkg::ADDR_LSB];
    assign chan      = addr[0];                                // [RULE_04]

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            last_cmd_ff <= 24'h000000;
        end else if (exec_go) begin
            last_cmd_ff <= exec_word;
        end
    end

    // ----------------------------------------
    // Nonvolatile store
    // ----------------------------------------
    logic [15:0]    nv_ff [0:14];
    logic [15:0]    tol_word;
    logic           nv_we;
    logic [3:0]     nv_wa;
    logic [15:0]    nv_wd;
    logic           por_pend_ff;

    // Sign-magnitude tolerance, fixed and read only
    always_comb begin
        tol_word = {pot_cmd_pkg::TOL_POSITIVE, pot_cmd_pkg::TOL_INT_PCT,
                    pot_cmd_pkg::TOL_FRAC};                   // [RULE_02] [RULE_18]
    end

    always_comb begin
        nv_we = 1'b0;
        nv_wa = addr;
        nv_wd = exec_word[15:0];
        if (exec_go && wp_s) begin                            // [RULE_07]
            if (cmd == pot_cmd_pkg::CMD_STORE_W && addr <= pot_cmd_pkg::NV_WIPER_TWO) begin
                nv_we = 1'b1;                                 // [RULE_06]
                nv_wd = {pot_cmd_pkg::WIPER_PAD,
                         chan ? wiper_position_two : wiper_position_one};
            end else if (cmd == pot_cmd_pkg::CMD_STORE_U &&
                         addr > pot_cmd_pkg::NV_WIPER_TWO &&
                         addr <= pot_cmd_pkg::NV_USER_LAST) begin
                nv_we = 1'b1;                                 // [RULE_12] [RULE_14]
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 15; i++) begin
                nv_ff[i] <= (i < 2) ? pot_cmd_pkg::NV_WIPER_INIT
                                    : pot_cmd_pkg::NV_USER_INIT;  // [RULE_13] [RULE_21]
            end
        end else if (nv_we) begin
            nv_ff[nv_wa] <= nv_wd;
        end
    end

    function automatic logic [15:0] nv_read(input logic [3:0] a);
        if (a == pot_cmd_pkg::NV_TOLERANCE) begin
            return tol_word;                                  // [RULE_21]
        end
        return nv_ff[a];
    endfunction : nv_read

    // ----------------------------------------
    // Wiper registers
    // ----------------------------------------
    logic [9:0]     w1_ff;
    logic [9:0]     w2_ff;
    logic [9:0]     nxt_w1;
    logic [9:0]     nxt_w2;
    logic [9:0]     sel_w;
    logic [9:0]     nv_w1;
    logic [9:0]     nv_w2;

    assign sel_w = chan ? w2_ff : w1_ff;
    assign nv_w1 = nv_ff[pot_cmd_pkg::NV_WIPER_ONE][9:0];
    assign nv_w2 = nv_ff[pot_cmd_pkg::NV_WIPER_TWO][9:0];

    always_comb begin
        nxt_w1 = w1_ff;
        nxt_w2 = w2_ff;
        if (por_pend_ff || recall_rise) begin
            nxt_w1 = nv_w1;                                   // [RULE_09]
            nxt_w2 = nv_w2;
        end else if (exec_go) begin
            case (cmd)
                pot_cmd_pkg::CMD_WRITE_W: begin
                    if (chan) nxt_w2 = exec_word[9:0];        // [RULE_04]
                    else nxt_w1 = exec_word[9:0];             // [RULE_01] [RULE_03]
                end
                pot_cmd_pkg::CMD_INC: begin
                    if (chan) nxt_w2 = inc_code(w2_ff);
                    else nxt_w1 = inc_code(w1_ff);            // [RULE_05]
                end
                pot_cmd_pkg::CMD_DOUBLE: begin
                    if (chan) nxt_w2 = dbl_code(w2_ff);       // [RULE_10]
                    else nxt_w1 = dbl_code(w1_ff);            // [RULE_11] [RULE_20]
                end
                pot_cmd_pkg::CMD_RESTORE: begin
                    if (chan) nxt_w2 = nv_w2;
                    else nxt_w1 = nv_w1;                      // [RULE_08]
                end
                default: begin
                    nxt_w1 = w1_ff;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            w1_ff       <= pot_cmd_pkg::WIPER_ZERO;
            w2_ff       <= pot_cmd_pkg::WIPER_ZERO;
            por_pend_ff <= 1'b1;
        end else begin
            w1_ff       <= nxt_w1;
            w2_ff       <= nxt_w2;
            por_pend_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Reply for the next frame
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reply_ff <= 24'h000000;
        end else if (exec_go) begin
            case (cmd)
                pot_cmd_pkg::CMD_READ_NV:
                    reply_ff <= {exec_word[23:16], nv_read(addr)};   // [RULE_15]
                pot_cmd_pkg::CMD_READ_W:
                    reply_ff <= {exec_word[23:16], pot_cmd_pkg::WIPER_PAD,
                                 sel_w};                            // [RULE_16]
                default:
                    reply_ff <= exec_word;                          // [RULE_17]
            endcase
        end
    end

    assign sdo                = sdo_ff;
    assign wiper_position_one = w1_ff;
    assign wiper_position_two = w2_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_frame_done;
        exec_go && !por_pend_ff && !recall_rise;
    endsequence

    sequence s_empty_strobe;
        frame_end && cnt_ff == 5'h00;
    endsequence

    wiper_write_a: assert property ( // [RULE_03]
        s_frame_done ##0 (cmd == pot_cmd_pkg::CMD_WRITE_W && !chan)
        |=> w1_ff == $past(exec_word[9:0]) && $stable(w2_ff))
        else $error("wiper one write not taken");

    inc_step_a: assert property ( // [RULE_05]
        s_frame_done ##0 (cmd == pot_cmd_pkg::CMD_INC && !chan &&
                          w1_ff != pot_cmd_pkg::WIPER_FULL)
        |=> w1_ff == $past(w1_ff) + 10'h001)
        else $error("increment not one code");

    double_sat_a: assert property ( // [RULE_11]
        s_frame_done ##0 (cmd == pot_cmd_pkg::CMD_DOUBLE &&
                          sel_w >= pot_cmd_pkg::WIPER_MID)
        |=> (chan ? w2_ff : w1_ff) == pot_cmd_pkg::WIPER_FULL)
        else $error("doubling did not saturate");

    double_zero_a: assert property ( // [RULE_20]
        s_frame_done ##0 (cmd == pot_cmd_pkg::CMD_DOUBLE && !chan &&
                          w1_ff == pot_cmd_pkg::WIPER_ZERO)
        |=> w1_ff == pot_cmd_pkg::WIPER_ONE)
        else $error("doubling zero did not give one");

    wp_block_a: assert property ( // [RULE_07]
        !wp_s |=> $stable(nv_ff[pot_cmd_pkg::NV_WIPER_ONE]) &&
                  $stable(nv_ff[pot_cmd_pkg::NV_WIPER_TWO]) &&
                  $stable(nv_ff[pot_cmd_pkg::NV_USER_LAST]))
        else $error("nonvolatile write while protected");

    recall_load_a: assert property ( // [RULE_09]
        recall_rise |=> w1_ff == $past(nv_w1) && w2_ff == $past(nv_w2))
        else $error("recall strobe did not reload wipers");

    wiper_rdback_a: assert property ( // [RULE_16]
        exec_go && cmd == pot_cmd_pkg::CMD_READ_W
        |=> reply_ff == {$past(exec_word[23:16]), pot_cmd_pkg::WIPER_PAD, $past(sel_w)})
        else $error("wiper readback word wrong");

    reexec_last_a: assert property ( // [RULE_19]
        s_empty_strobe ##0 (!por_pend_ff && !recall_rise &&
            last_cmd_ff[pot_cmd_pkg::CMD_MSB:pot_cmd_pkg::CMD_LSB] == pot_cmd_pkg::CMD_INC &&
            !last_cmd_ff[pot_cmd_pkg::ADDR_LSB] && w1_ff != pot_cmd_pkg::WIPER_FULL)
        |=> w1_ff == $past(w1_ff) + 10'h001)
        else $error("empty strobe did not repeat command");

    first_bit_a: assert property ( // [RULE_17]
        state_ff == pot_cmd_pkg::FR_IDLE && cs_fall
        |=> sdo == $past(reply_ff[23]) ##1 tx_ff[23] == sdo)
        else $error("first output bit not from reply");
endmodule : dual_pot_serial_command_unit

// [test/host_link_model.sv]
// Host side model that drives the serial link of the command unit
`timescale 1ns/1ps
module host_link_model (
    input  wire logic mclk, // Timing reference for the link
    input  wire logic sdo,  // Serial data from the device
    output logic      sclk, // Link clock, still between frames
    output logic      cs_n, // Frame select, active low
    output logic      sdi   // Serial data to the device
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_clk

    // MSB first, 320 ns link period; sdo taken mid high phase
    task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
        rx = 24'h000000;
        @(negedge mclk);
        cs_n = 1'b0;
        wait_clk(2);
        for (int i = 0; i < nbits; i++) begin
            sdi = tx[23 - i];
            wait_clk(4);
            sclk = 1'b1;
            wait_clk(2);
            rx = {rx[22:0], sdo};
            wait_clk(2);
            sclk = 1'b0;
        end
        wait_clk(4);
        cs_n = 1'b1;
        // Released data line must not keep showing the last bit
        sdi = ~sdi;
        wait_clk(8);
    endtask : xfer
endmodule : host_link_model

// [test/dual_pot_serial_command_unit_tb.sv]
// Self-checking bench for the dual wiper serial command unit
`timescale 1ns/1ps
module dual_pot_serial_command_unit_tb;
    localparam int CYCLE_LIMIT = 20000;

    logic        mclk = 1'b0;
    logic        rstn;
    logic        wp_n;
    logic        preset_recall_n;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic [9:0]  wiper_position_one;
    logic [9:0]  wiper_position_two;
    logic [23:0] rx;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;

    always #20 mclk = ~mclk;

    dual_pot_serial_command_unit DUT (
        .mclk               (mclk),
        .rstn               (rstn),
        .sclk               (sclk),
        .cs_n               (cs_n),
        .sdi                (sdi),
        .wp_n               (wp_n),
        .preset_recall_n    (preset_recall_n),
        .sdo                (sdo),
        .wiper_position_one (wiper_position_one),
        .wiper_position_two (wiper_position_two)
    );

    host_link_model host (
        .mclk (mclk),
        .sdo  (sdo),
        .sclk (sclk),
        .cs_n (cs_n),
        .sdi  (sdi)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic send(input logic [23:0] tx);
        host.xfer(tx, 24, rx);
    endtask : send

    task automatic summarize;
        if (miscompares == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            miscompares++;
            summarize();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_write;
        chk_code(wiper_position_one, 10'h200);
        send(24'hb0ffff);
        chk_code(wiper_position_one, 10'h3ff);
        send(24'hb00100);
        chk_code(wiper_position_one, 10'h100);
        send(24'hb10155);
        chk_code(wiper_position_two, 10'h155);
        chk_code(wiper_position_one, 10'h100);
        chk_word(rx, 24'hb00100);
    endtask : t_write

    task automatic t_increment;
        send(24'he0ffff);
        chk_code(wiper_position_one, 10'h101);
        send(24'he00000);
        chk_code(wiper_position_one, 10'h102);
        chk_word(rx, 24'he0ffff);
        host.xfer(24'h000000, 0, rx);
        chk_code(wiper_position_one, 10'h103);
        host.xfer(24'hb00000, 16, rx);
        chk_code(wiper_position_one, 10'h103);
    endtask : t_increment

    task automatic t_store_restore;
        send(24'h200000);
        send(24'hb00010);
        send(24'h100000);
        chk_code(wiper_position_one, 10'h103);
        wp_n = 1'b0;
        send(24'hb003f0);
        send(24'h200000);
        send(24'h32beef);
        send(24'h100000);
        chk_code(wiper_position_one, 10'h103);
        wp_n = 1'b1;
        send(24'h920000);
        send(24'h000000);
        chk_word(rx, 24'h920000);
        send(24'hb00050);
        send(24'hb10060);
        preset_recall_n = 1'b0;
        host.wait_clk(6);
        preset_recall_n = 1'b1;
        host.wait_clk(8);
        chk_code(wiper_position_one, 10'h103);
        chk_code(wiper_position_two, 10'h200);
        send(24'hb10077);
        send(24'h210000);
        send(24'hb10011);
        send(24'h110000);
        chk_code(wiper_position_two, 10'h077);
        send(24'he10000);
        chk_code(wiper_position_two, 10'h078);
    endtask : t_store_restore

    task automatic t_double;
        send(24'hb00200);
        send(24'hc00000);
        chk_code(wiper_position_one, 10'h3ff);
        send(24'he00000);
        chk_code(wiper_position_one, 10'h3ff);
        send(24'ha00000);
        send(24'h000000);
        chk_word(rx, 24'ha003ff);
        send(24'hb00000);
        send(24'hc00000);
        chk_code(wiper_position_one, 10'h001);
        send(24'hb00300);
        send(24'hc00000);
        chk_code(wiper_position_one, 10'h3ff);
        send(24'hb10123);
        send(24'hc10000);
        chk_code(wiper_position_two, 10'h246);
        chk_code(wiper_position_one, 10'h3ff);
        send(24'ha10000);
        send(24'h000000);
        chk_word(rx, 24'ha10246);
    endtask : t_double

    task automatic t_user;
        send(24'h32aaaa);
        send(24'h335555);
        chk_word(rx, 24'h32aaaa);
        send(24'h920000);
        send(24'h000000);
        chk_word(rx, 24'h92aaaa);
        send(24'h930000);
        send(24'h000000);
        chk_word(rx, 24'h935555);
        send(24'h3e1234);
        send(24'h9e0000);
        send(24'h000000);
        chk_word(rx, 24'h9e1234);
        send(24'h3fffff);
        send(24'h9f0000);
        send(24'h000000);
        chk_word(rx, 24'h9f8000);
    endtask : t_user

    task automatic t_reset;
        send(24'hb00155);
        rstn = 1'b0;
        host.wait_clk(4);
        rstn = 1'b1;
        host.wait_clk(6);
        chk_code(wiper_position_one, 10'h200);
        chk_code(wiper_position_two, 10'h200);
    endtask : t_reset

    initial begin
        rstn            = 1'b0;
        wp_n            = 1'b1;
        preset_recall_n = 1'b1;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        repeat (6) @(negedge mclk);
        t_write();
        t_increment();
        t_store_restore();
        t_double();
        t_user();
        t_reset();
        summarize();
    end
endmodule : dual_pot_serial_command_unit_tb
